// ==== smpm_consts.vh ====
`ifndef SMPM_CONSTS_VH
`define SMPM_CONSTS_VH
// ----------------------------------------
// register map (byte addresses, word aligned)
// ----------------------------------------
`define SMPM_IDX_SLEEP_CTRL   8'h33
`define SMPM_ADDR_SLEEP_CTRL  12'h0cc
`define SMPM_ADDR_PWR_RED     12'h100
`define SMPM_ADDR_CONFIG      12'h104
`define SMPM_ADDR_STATUS      12'h108
// ----------------------------------------
// field positions
// ----------------------------------------
`define SMPM_SE_BIT           0
`define SMPM_SM_LSB           1
`define SMPM_SM_MSB           3
`define SMPM_SLEEP_CTRL_RST   8'h00
`define SMPM_PWR_RED_RST      8'h00
`define SMPM_PWR_RED_MASK     8'hef
`define SMPM_PR_TIMER2_BIT    6
`define SMPM_PR_ADC_BIT       0
// config bits
`define SMPM_CFG_ASYNC_BIT    0
`define SMPM_CFG_SYNC_BIT     1
`define SMPM_CFG_ACBG_BIT     2
`define SMPM_CFG_RST          8'h00
// ----------------------------------------
// sleep mode codes
// ----------------------------------------
`define SMPM_SM_IDLE          3'h0
`define SMPM_SM_ADCNR         3'h1
`define SMPM_SM_PDOWN         3'h2
`define SMPM_SM_PSAVE         3'h3
`define SMPM_SM_STBY          3'h6
`define SMPM_SM_XSTBY         3'h7
// ----------------------------------------
// timing
// ----------------------------------------
`define SMPM_STBY_WAKE_CYC    4'h6
`define SMPM_IRQ_HALT_CYC     4'h4
`define SMPM_STARTUP_CYC_DEF  16
`endif

// ==== smpm_top.v ====
`timescale 1ns/1ps
`include "smpm_consts.vh"
`default_nettype none
module smpm_top #(
  parameter [15:0] STARTUP_CYC = `SMPM_STARTUP_CYC_DEF
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // core side
  input  wire        sleep_instr,
  input  wire        core_status_flags_i,
  output reg         core_halt,
  output reg         wake_irq_take,
  // fuses and peripheral enables
  input  wire        ext_crystal_sel,
  input  wire        brownout_level_fuses,
  input  wire        debug_enable_fuse,
  input  wire        wdt_enable,
  input  wire        adc_enable,
  input  wire        acomp_enable,
  input  wire [1:0]  async_timer_irq_mask,
  // wake sources
  input  wire        wake_ext_level,
  input  wire        wake_pin_change,
  input  wire        wake_addr_match,
  input  wire        wake_wdt,
  input  wire        wake_timer_ovf,
  input  wire        wake_timer_cmp,
  input  wire        wake_adc_done,
  input  wire        wake_other_io,
  // clock enables and analog controls
  output reg         cpu_clk_en,
  output reg         flash_clk_en,
  output reg         io_clock_en,
  output reg         converter_clock_en,
  output reg         async_clk_en,
  output reg         main_osc_en,
  output reg         timer_osc_en,
  output reg         timer_sync_clk_en,
  output reg  [7:0]  module_clk_en,
  output reg  [7:0]  module_reg_block,
  output reg         input_buf_en,
  output reg         acomp_active,
  output reg         vref_en,
  output reg         bod_active,
  output reg         wdt_run,
  output reg         adc_active,
  output reg         adc_extended_conv
);

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  // one-hot; ST_FAST skips the start-up wait because the oscillator never stopped
  localparam [4:0] ST_RUN   = 5'h01;
  localparam [4:0] ST_SLEEP = 5'h02;
  localparam [4:0] ST_START = 5'h04;
  localparam [4:0] ST_HALT  = 5'h08;
  localparam [4:0] ST_FAST  = 5'h10;

  // mode decode, used once, for the requested mode sel_mode
  function [2:0] eff_mode;
    input [2:0] code;
    input       xtal;
    begin
      case (code)
        `SMPM_SM_IDLE, `SMPM_SM_ADCNR, `SMPM_SM_PDOWN, `SMPM_SM_PSAVE: begin
          eff_mode = code;
        end
        `SMPM_SM_STBY, `SMPM_SM_XSTBY: begin
          eff_mode = xtal ? code : `SMPM_SM_IDLE;
        end
        default: begin
          eff_mode = `SMPM_SM_IDLE; // reserved codes fall back
        end
      endcase
    end
  endfunction

  // deep modes that keep the main oscillator alive while asleep (idle and noise reduction keep it too)
  function osc_kept;
    input [2:0] code;
    begin
      osc_kept = (code == `SMPM_SM_STBY) | (code == `SMPM_SM_XSTBY);
    end
  endfunction

  // deep modes in which the async timer may stay clocked (idle and noise reduction clock it too)
  function timer_kept;
    input [2:0] code;
    begin
      timer_kept = (code == `SMPM_SM_PSAVE) | (code == `SMPM_SM_XSTBY);
    end
  endfunction

  // architectural registers and wake sequencing state
  reg [7:0]  sleep_ctrl_ff;
  reg [7:0]  pwr_red_ff;
  reg [7:0]  cfg_ff;
  reg [4:0]  state_ff;
  reg [2:0]  mode_ff;
  reg [15:0] cnt_ff;
  reg        irq_ff;
  reg        adc_was_on_ff;
  reg        ph_valid_ff;
  reg        ph_write_ff;
  reg [11:0] ph_addr_ff;

  // next values from the sequencing process
  reg [4:0]  nxt_state;
  reg [15:0] nxt_cnt;
  reg        nxt_irq;
  reg [2:0]  nxt_mode;

  // requested mode, latched into mode_ff only when the sleep is taken
  wire [2:0] sel_mode = eff_mode(sleep_ctrl_ff[`SMPM_SM_MSB:`SMPM_SM_LSB], ext_crystal_sel);
  wire       asleep   = (state_ff == ST_SLEEP);
  wire       gie      = core_status_flags_i;
  wire       tmr_ok   = cfg_ff[`SMPM_CFG_ASYNC_BIT] | cfg_ff[`SMPM_CFG_SYNC_BIT];
  wire       tmr_wake = tmr_ok & gie &
                        ((wake_timer_ovf & async_timer_irq_mask[0]) |
                         (wake_timer_cmp & async_timer_irq_mask[1]));
  wire       deep_wake = wake_ext_level | wake_pin_change | wake_addr_match | wake_wdt;
  reg        wake_ok;

  // ----------------------------------------
  // wake qualification per mode
  // ----------------------------------------
  // idle wakes on any source; deeper modes only on their own sources
  // a timer event counts only with its mask bit and the global enable set
  always @* begin
    case (mode_ff)
      `SMPM_SM_IDLE:  wake_ok = deep_wake | tmr_wake | wake_adc_done | wake_other_io;
      `SMPM_SM_ADCNR: wake_ok = deep_wake | tmr_wake | wake_adc_done;
      `SMPM_SM_PSAVE, `SMPM_SM_XSTBY: wake_ok = deep_wake | tmr_wake;
      default:        wake_ok = deep_wake;
    endcase
  end

  // ----------------------------------------
  // sleep sequencing
  // ----------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_irq   = irq_ff;
    nxt_mode  = mode_ff;
    case (state_ff)
      ST_RUN: begin
        if (sleep_instr && sleep_ctrl_ff[`SMPM_SE_BIT]) begin
          nxt_state = ST_SLEEP;
          nxt_mode  = sel_mode;
        end
      end
      ST_SLEEP: begin
        if (wake_ok) begin
          nxt_irq = 1'b1;
          if (osc_kept(mode_ff) ||
              mode_ff == `SMPM_SM_IDLE || mode_ff == `SMPM_SM_ADCNR) begin
            nxt_state = ST_FAST; // oscillator still up
            nxt_cnt   = {12'h000, `SMPM_STBY_WAKE_CYC} - 16'h0002;
          end else begin
            nxt_state = ST_START; // clock must restart first
            nxt_cnt   = STARTUP_CYC - 16'h0001;
          end
        end
      end
      ST_START: begin
        if (cnt_ff == 16'h0000) begin
          // level source gone: wake anyway but drop the interrupt
          nxt_irq   = irq_ff & wake_ok;
          nxt_state = ST_HALT;
          nxt_cnt   = {12'h000, `SMPM_IRQ_HALT_CYC} - 16'h0001;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      ST_FAST: begin
        if (cnt_ff == 16'h0000) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      ST_HALT: begin
        if (cnt_ff == 16'h0000) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // sequencing registers; the interrupt flag clears on return to run
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_RUN;
      cnt_ff   <= 16'h0000;
      irq_ff   <= 1'b0;
      mode_ff  <= `SMPM_SM_IDLE;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      irq_ff   <= (nxt_state == ST_RUN) ? 1'b0 : nxt_irq;
      mode_ff  <= nxt_mode;
    end
  end

  // ----------------------------------------
  // clock gating and analog controls
  // ----------------------------------------
  // only sleep state gates, except cpu_clk_en, which stays off through the wake-up phases until the return to run
  wire m_idle  = asleep & (mode_ff == `SMPM_SM_IDLE);
  wire m_adcnr = asleep & (mode_ff == `SMPM_SM_ADCNR);
  // power-save and extended standby both let the async timer run
  wire m_psv   = asleep & timer_kept(mode_ff);
  wire m_osc   = asleep & osc_kept(mode_ff);
  wire io_on   = ~asleep | m_idle;
  wire adc_on  = ~asleep | m_idle | m_adcnr;
  wire shallow = io_on | adc_on; // active, idle or noise reduction
  wire ac_on   = acomp_enable & shallow;
  wire tmr_en  = ~pwr_red_ff[`SMPM_PR_TIMER2_BIT];
  wire main_on = ~asleep | m_idle | m_adcnr | m_osc | debug_enable_fuse |
                 (m_psv & cfg_ff[`SMPM_CFG_SYNC_BIT] & tmr_en);
  wire [7:0] pr_eff = pwr_red_ff & {8{io_on}};

  // one gate per reduction bit; a stopped module keeps its state since
  // only its clock goes away, never its reset
  wire [7:0] nxt_mod_clk;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mod_gate
      assign nxt_mod_clk[gi] = io_on & ~pr_eff[gi];
    end
  endgenerate

  // every control output is registered so no glitch reaches a gate
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en         <= 1'b1;
      flash_clk_en       <= 1'b1;
      io_clock_en        <= 1'b1;
      converter_clock_en <= 1'b1;
      async_clk_en       <= 1'b1;
      main_osc_en        <= 1'b1;
      timer_osc_en       <= 1'b0;
      timer_sync_clk_en  <= 1'b1;
      module_clk_en      <= 8'hff;
      module_reg_block   <= 8'h00;
      input_buf_en       <= 1'b1;
      acomp_active       <= 1'b0;
      vref_en            <= 1'b0;
      bod_active         <= 1'b0;
      wdt_run            <= 1'b0;
      adc_active         <= 1'b0;
      adc_extended_conv  <= 1'b0;
      adc_was_on_ff      <= 1'b0;
      core_halt          <= 1'b0;
      wake_irq_take      <= 1'b0;
    end else begin
      cpu_clk_en         <= ~asleep & (nxt_state == ST_RUN);
      flash_clk_en       <= ~asleep;
      io_clock_en        <= io_on;
      converter_clock_en <= adc_on & ~pwr_red_ff[`SMPM_PR_ADC_BIT];
      async_clk_en       <= shallow | (m_psv & tmr_en);
      main_osc_en        <= main_on;
      timer_osc_en       <= cfg_ff[`SMPM_CFG_ASYNC_BIT] & (shallow | m_psv);
      timer_sync_clk_en  <= cfg_ff[`SMPM_CFG_SYNC_BIT] & tmr_en &
                            (io_on | m_psv); // routed to the timer alone
      module_clk_en      <= nxt_mod_clk;
      module_reg_block   <= pwr_red_ff;
      input_buf_en       <= io_on | adc_on; // wake pins bypass this gate
      acomp_active       <= ac_on;
      vref_en            <= brownout_level_fuses | adc_enable |
                            (acomp_enable & cfg_ff[`SMPM_CFG_ACBG_BIT]);
      bod_active         <= brownout_level_fuses;
      wdt_run            <= wdt_enable;
      adc_active         <= adc_enable;
      adc_was_on_ff      <= adc_enable;
      adc_extended_conv  <= (adc_enable & ~adc_was_on_ff) |
                            (adc_extended_conv & adc_enable & ~wake_adc_done);
      core_halt          <= (nxt_state != ST_RUN);
      wake_irq_take      <= irq_ff & (state_ff != ST_RUN) & (nxt_state == ST_RUN);
    end
  end

  // ----------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------
  // address phase is latched here; write data lands one cycle later
  // no wait states: every register answers in the following data phase
  wire ap_take = hsel & hready & htrans[1];

  // reserved bits are dropped on write, so they always read back as zero
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_valid_ff   <= 1'b0;
      ph_write_ff   <= 1'b0;
      ph_addr_ff    <= 12'h000;
      sleep_ctrl_ff <= `SMPM_SLEEP_CTRL_RST;
      pwr_red_ff    <= `SMPM_PWR_RED_RST;
      cfg_ff        <= `SMPM_CFG_RST;
      hrdata        <= 32'h0000_0000;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
    end else begin
      ph_valid_ff <= ap_take;
      ph_write_ff <= hwrite;
      ph_addr_ff  <= haddr;
      // writes use the latched address with data from the data phase
      if (ph_valid_ff && ph_write_ff) begin
        case (ph_addr_ff)
          `SMPM_ADDR_SLEEP_CTRL: sleep_ctrl_ff <= {4'h0, hwdata[3:0]};
          `SMPM_ADDR_PWR_RED:    pwr_red_ff    <= hwdata[7:0] & `SMPM_PWR_RED_MASK;
          `SMPM_ADDR_CONFIG:     cfg_ff        <= {5'h00, hwdata[2:0]};
          default: begin
          end
        endcase
      end
      // read data registered at the address phase, valid in the data phase
      if (ap_take && !hwrite) begin
        case (haddr)
          `SMPM_ADDR_SLEEP_CTRL: hrdata <= {24'h000000, sleep_ctrl_ff};
          `SMPM_ADDR_PWR_RED:    hrdata <= {24'h000000, pwr_red_ff};
          `SMPM_ADDR_CONFIG:     hrdata <= {24'h000000, cfg_ff};
          `SMPM_ADDR_STATUS:     hrdata <= {21'h0, mode_ff, 3'h0, state_ff}; // mode in [10:8]
          default:               hrdata <= 32'h0000_0000;
        endcase
      end
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== smpm_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// power manager port checker
// ----------------------------------------
module smpm_top_asserts (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // core side and fuses
  input wire logic       sleep_instr,
  input wire logic       core_halt,
  input wire logic       wake_irq_take,
  input wire logic       brownout_level_fuses,
  input wire logic       debug_enable_fuse,
  input wire logic       wdt_enable,
  input wire logic       adc_enable,
  input wire logic       acomp_enable,
  // clock enables and analog controls
  input wire logic       cpu_clk_en,
  input wire logic       flash_clk_en,
  input wire logic       io_clock_en,
  input wire logic       main_osc_en,
  input wire logic [7:0] module_clk_en,
  input wire logic [7:0] module_reg_block,
  input wire logic       vref_en,
  input wire logic       bod_active,
  input wire logic       wdt_run,
  input wire logic       adc_active
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // sleep entry only ever follows a sleep instruction
  a_halt_after_instr: assert property ($rose(core_halt) |-> $past(sleep_instr))
    else $error("halt rose without a sleep instruction");
  // two awake cycles leave room for the wake sequence to restart clocks
  a_awake_cpu_on: assert property (
    !core_halt && !$past(core_halt) |-> cpu_clk_en && flash_clk_en)
    else $error("cpu clocks off while awake");
  a_prr_gates_mods: assert property (
    !core_halt && !$past(core_halt) && $stable(module_reg_block)
    |-> module_clk_en == ~module_reg_block)
    else $error("module clocks disagree with reduction bits");
  a_sleep_mods_off: assert property (
    core_halt && $past(core_halt) && !io_clock_en
    && !$past(io_clock_en) |-> module_clk_en == 8'h00)
    else $error("module clock running in deep sleep");
  a_bod_kept_on: assert property (brownout_level_fuses |=> bod_active)
    else $error("brown-out detector dropped");
  a_wdt_kept_on: assert property (wdt_enable |=> wdt_run)
    else $error("watchdog stopped");
  a_dbg_osc_on: assert property (debug_enable_fuse |=> main_osc_en)
    else $error("main oscillator stopped under debug");
  a_adc_kept_on: assert property (adc_enable |=> adc_active)
    else $error("converter dropped while enabled");
  a_vref_unused_off: assert property (
    !(brownout_level_fuses || adc_enable || acomp_enable) [*2]
    |-> !vref_en)
    else $error("reference on with no user");
  a_irq_one_pulse: assert property (wake_irq_take |=> !wake_irq_take)
    else $error("wake interrupt pulse too long");
endmodule

bind smpm_top smpm_top_asserts u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .sleep_instr(sleep_instr), .core_halt(core_halt),
  .wake_irq_take(wake_irq_take), .brownout_level_fuses(brownout_level_fuses),
  .debug_enable_fuse(debug_enable_fuse), .wdt_enable(wdt_enable), .adc_enable(adc_enable),
  .acomp_enable(acomp_enable), .cpu_clk_en(cpu_clk_en), .flash_clk_en(flash_clk_en),
  .io_clock_en(io_clock_en), .main_osc_en(main_osc_en), .module_clk_en(module_clk_en),
  .module_reg_block(module_reg_block), .vref_en(vref_en), .bod_active(bod_active),
  .wdt_run(wdt_run), .adc_active(adc_active)
);
`default_nettype wire

// ==== smpm_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// core and wake-source model
// ----------------------------------------
module smpm_core_model (
  // clock and core state
  input  wire logic       core_clk,
  input  wire logic       core_halt,
  // toward the power manager
  output var  logic       sleep_instr,
  output var  logic [2:0] wake_src
);
  logic hold_ff;
  logic drop_ff;

  initial begin
    sleep_instr = 1'b0;
    wake_src = 3'h0;
    hold_ff = 1'b0;
    drop_ff = 1'b0;
  end
  // one-cycle sleep instruction, enable bit written just before
  task automatic do_sleep();
    @(posedge core_clk);
    sleep_instr <= 1'b1;
    @(posedge core_clk);
    sleep_instr <= 1'b0;
  endtask
  // raise a wake level: held until the core runs, or a one-cycle glitch
  task automatic raise(input logic [2:0] src, input logic brief);
    @(posedge core_clk);
    wake_src <= src;
    hold_ff <= ~brief;
    drop_ff <= brief;
  endtask
  // handler clears the source once running; a glitch ends before start-up
  always @(posedge core_clk) begin
    if (drop_ff || (hold_ff && core_halt === 1'b0)) begin
      wake_src <= 3'h0;
      hold_ff <= 1'b0;
      drop_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "smpm_consts.vh"
module testbench;
  localparam int STUP = 4;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  mask = 2'h0;
  logic        gie = 1'b1, xtal = 1'b0, bodf = 1'b0, dbg = 1'b0;
  logic        wdt = 1'b0, adc = 1'b0, acmp = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout, core_halt, irq_take, sleep_instr, hresp, xconv;
  logic [2:0]  wsrc;
  logic        cpu_en, io_en, conv_en, asy_en, osc_en, tosc_en, tsync_en, ibuf, acmp_on, vref;
  logic [7:0]  mclk, mblk;
  int          fails = 0, tests_run = 0, irqs = 0, n;

  // ----------------------------------------
  // clock, design and core model
  // ----------------------------------------
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (irq_take === 1'b1) irqs++;

  smpm_top #(.STARTUP_CYC(16'(STUP))) dut (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sleep_instr(sleep_instr), .core_status_flags_i(gie),
    .core_halt(core_halt), .wake_irq_take(irq_take), .ext_crystal_sel(xtal),
    .brownout_level_fuses(bodf), .debug_enable_fuse(dbg), .wdt_enable(wdt), .adc_enable(adc),
    .acomp_enable(acmp), .async_timer_irq_mask(mask), .wake_ext_level(wsrc[1]),
    .wake_pin_change(wsrc[0]), .wake_addr_match(1'b0), .wake_wdt(1'b0),
    .wake_timer_ovf(wsrc[2]), .wake_timer_cmp(1'b0), .wake_adc_done(1'b0),
    .wake_other_io(1'b0), .cpu_clk_en(cpu_en), .flash_clk_en(), .io_clock_en(io_en),
    .converter_clock_en(conv_en), .async_clk_en(asy_en), .main_osc_en(osc_en),
    .timer_osc_en(tosc_en), .timer_sync_clk_en(tsync_en), .module_clk_en(mclk),
    .module_reg_block(mblk), .input_buf_en(ibuf), .acomp_active(acmp_on), .vref_en(vref),
    .bod_active(), .wdt_run(), .adc_active(), .adc_extended_conv(xconv)
  );
  smpm_core_model m (.core_clk(core_clk), .core_halt(core_halt), .sleep_instr(sleep_instr),
    .wake_src(wsrc));

  // ----------------------------------------
  // bus, compare and sleep tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // single word transfer; each phase held until hready is sampled high
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(nm, exp, d);
  endtask
  // select a mode with the enable bit set, then execute sleep
  task automatic sleep(input logic [2:0] code);
    wr(`SMPM_ADDR_SLEEP_CTRL, {28'h0, code, 1'b1});
    m.do_sleep();
    repeat (3) @(posedge core_clk);
  endtask
  // count edges from the wake level until the core runs again
  task automatic wake(input logic [2:0] src, input logic brief);
    irqs = 0;
    m.raise(src, brief);
    n = 0;
    while (core_halt === 1'b1 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    repeat (3) @(posedge core_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    results();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rchk("ctrl reset", `SMPM_ADDR_SLEEP_CTRL, 32'h0);
    wr(`SMPM_ADDR_SLEEP_CTRL, 32'hffff_fffe);
    rchk("ctrl upper bits", `SMPM_ADDR_SLEEP_CTRL, 32'h0e);
    chk("bus response okay", 32'h0, {31'h0, hresp});
    m.do_sleep();
    repeat (3) @(posedge core_clk);
    chk("no sleep without enable", 32'h0, {31'h0, core_halt});
    rchk("unmapped", 12'h0f0, 32'h0);
    wr(`SMPM_ADDR_PWR_RED, 32'hff);
    rchk("reduction bits", `SMPM_ADDR_PWR_RED, 32'hef);
    repeat (2) @(posedge core_clk);
    chk("module clocks off", 32'h10, {24'h0, mclk});
    chk("module regs blocked", 32'hef, {24'h0, mblk});
    wr(`SMPM_ADDR_PWR_RED, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("module clocks back", 32'hff, {24'h0, mclk});
    bodf <= 1'b1;
    wdt <= 1'b1;
    adc <= 1'b1;
    acmp <= 1'b1;
    sleep(`SMPM_SM_PDOWN);
    chk("pd clocks", 32'h0, {27'h0, cpu_en, io_en, osc_en, asy_en, conv_en});
    chk("pd input buffers", 32'h0, {31'h0, ibuf});
    chk("pd comparator", 32'h0, {31'h0, acmp_on});
    chk("pd reference", 32'h1, {31'h0, vref});
    chk("pd extended conv", 32'h1, {31'h0, xconv});
    wake(3'h1, 1'b0);
    chk("pd start-up wait", 32'h1, {31'h0, n >= STUP + 4 && n < STUP + 8});
    chk("pd wake irq", 32'h1, 32'(irqs));
    rchk("status after pd", `SMPM_ADDR_STATUS, {21'h0, `SMPM_SM_PDOWN, 3'h0, 5'h01});
    sleep(`SMPM_SM_PDOWN);
    wake(3'h2, 1'b1);
    chk("glitch wakes", 32'h0, {31'h0, core_halt});
    chk("glitch no irq", 32'h0, 32'(irqs));
    bodf <= 1'b0;
    adc <= 1'b0;
    acmp <= 1'b0;
    mask <= 2'h1;
    wr(`SMPM_ADDR_CONFIG, 32'h1);
    sleep(`SMPM_SM_PSAVE);
    chk("ps timer osc", 32'h3, {30'h0, tosc_en, asy_en});
    chk("ps main clock", 32'h0, {30'h0, osc_en, tsync_en});
    wake(3'h4, 1'b0);
    chk("ps timer wake", 32'h1, {31'h0, n >= STUP + 4 && n < STUP + 8});
    sleep(`SMPM_SM_PSAVE);
    gie <= 1'b0;
    wake(3'h4, 1'b1);
    chk("ps no wake without gie", 32'h1, {31'h0, core_halt});
    gie <= 1'b1;
    wake(3'h1, 1'b0);
    xtal <= 1'b1;
    sleep(`SMPM_SM_STBY);
    chk("stby osc", 32'h2, {30'h0, osc_en, cpu_en});
    wake(3'h1, 1'b0);
    chk("stby resume", 32'h1, {31'h0, n <= 7});
    sleep(`SMPM_SM_XSTBY);
    chk("xstby osc", 32'h3, {30'h0, osc_en, asy_en});
    wake(3'h1, 1'b0);
    chk("xstby resume", 32'h1, {31'h0, n <= 7});
    dbg <= 1'b1;
    sleep(`SMPM_SM_PDOWN);
    chk("pd debug osc", 32'h1, {31'h0, osc_en});
    wake(3'h1, 1'b0);
    sleep(3'h4);
    chk("reserved as idle", 32'h7, {29'h0, core_halt, io_en, osc_en});
    wake(3'h1, 1'b0);
    xtal <= 1'b0;
    dbg <= 1'b0;
    sleep(`SMPM_SM_STBY);
    chk("stby no crystal", 32'h3, {30'h0, core_halt, io_en});
    wake(3'h1, 1'b0);
    chk("idle resume", 32'h1, {31'h0, n <= 7});
    results();
  end
endmodule
`default_nettype wire
